/* File: asc_pkg.sv */
// Constants, types and register map for the analog scaling curve block.
// Assumes a single 200 MHz clock; values are signed fixed point with FRAC fraction bits.
package curve_pkg;

  // ------------------------------------------------------------
  // Sizes and number format
  // ------------------------------------------------------------
  localparam int NUM_CURVES = 4;
  localparam int NUM_POINTS = 20;
  localparam int NUM_SRC = 42;
  localparam int FRAC = 8;
  localparam logic [4:0] LAST_PT = 5'h13;
  localparam logic [4:0] FIRST_EXTRA_PT = 5'h02;

  typedef logic signed [31:0] value_t;

  localparam value_t ONE_VAL = value_t'(1) <<< FRAC;
  localparam value_t HALF_VAL = value_t'(1) <<< (FRAC - 1);
  localparam value_t FRAC_MASK = ONE_VAL - value_t'(1);
  localparam value_t IN_LIMIT = value_t'(4000) <<< FRAC;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_NS = 5_000_000;
  localparam int STEP_CYCLES_DEF = STEP_NS / CLK_PERIOD_NS;
  localparam int STEP_MS = 5;
  localparam int UPD_MS = 150;
  localparam int TAU_MS = 1000;
  localparam logic [15:0] UPD_DEF = 16'(UPD_MS / STEP_MS);
  localparam logic [19:0] TAU_DEF = 20'(TAU_MS / STEP_MS);

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam logic [2:0] GLOBAL_BLK = 3'h4;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UPD = 8'h04;
  localparam logic [7:0] OFS_TAU = 8'h08;
  localparam logic [7:0] OFS_MIN = 8'h0c;
  localparam logic [7:0] OFS_MAX = 8'h10;
  localparam logic [7:0] OFS_USED = 8'h14;
  localparam logic [7:0] OFS_IN = 8'h18;
  localparam logic [7:0] OFS_OUT = 8'h1c;
  localparam logic [7:0] OFS_X = 8'h20;
  localparam logic [7:0] OFS_Y = 8'h70;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam int CTRL_EN = 0;
  localparam int CTRL_FILT = 1;
  localparam int CTRL_OOR = 2;
  localparam int CTRL_HAND_LSB = 3;
  localparam int CTRL_SEL_LSB = 8;
  localparam int ST_OOR_LSB = 0;
  localparam int ST_DONE_LSB = 4;
  localparam logic [19:0] USED_FIXED = 20'h00003;

  typedef enum logic [1:0] {
    HAND_FLOAT = 2'b00,
    HAND_FLOOR = 2'b01,
    HAND_CEIL = 2'b10,
    HAND_NEAR = 2'b11
  } hand_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_CALC = 2'b10
  } state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic en;
    logic filt;
    logic oor;
    hand_t hand;
    logic [5:0] sel;
    logic [15:0] upd;
    logic [19:0] tau;
    value_t vmin;
    value_t vmax;
    logic [19:0] used;
  } cfg_t;

  localparam cfg_t CFG_RST = '{en: 1'b0, filt: 1'b0, oor: 1'b0, hand: HAND_FLOAT, sel: 6'h00,
                               upd: UPD_DEF, tau: TAU_DEF, vmin: '0, vmax: '0, used: USED_FIXED};

endpackage

/* File: analog_scaling_curve.sv */
// Four analog input scaling curves with filter, limit check, hold and rounding.
// Assumes sources and register master run on SYS_CLK; no synchronisers needed.
`timescale 1ns/100ps

// Overview of operation
// - Optional first-order low-pass filter on input
// - Flag input below minimum or above maximum
// - Four independent curves, each own flag
// - Lost input holds last valid value
// - Refresh per update cycle in 5 ms steps
// - Output float, floor, ceiling or nearest
// - Default two-point linear map, 0 and 1
// - Points 3 to 20 individually enabled
// - Input source chosen by index code
// - Filter time constant in 5 ms steps
// - Range flag only when check enabled
module analog_scaling_curve
  import curve_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Register port
  input wire reg_req_t REG_REQ,
  output logic [31:0] REG_RDATA,
  // Measurement channels
  input wire value_t [NUM_SRC-1:0] SRC_VALUE,
  input wire logic [NUM_SRC-1:0] SRC_VALID,
  // Curve results
  output value_t [NUM_CURVES-1:0] CURVE_VALUE,
  output logic [NUM_CURVES-1:0] CURVE_OUT_OF_RANGE,
  output logic IRQ
);

  // ------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------
  // Wide intermediates keep the products exact before the divide
  function automatic value_t filt_step(value_t x, value_t y, logic [15:0] upd, logic [19:0] tau);
    logic signed [63:0] n;
    logic signed [63:0] den;
    begin
      den = 64'(tau) + 64'(upd);
      n = (64'(x) - 64'(y)) * 64'(upd);
      if (den == 64'sh0)
        return x;
      return value_t'(64'(y) + n / den);
    end
  endfunction

  function automatic value_t interp(value_t x, value_t xa, value_t xb, value_t ya, value_t yb);
    logic signed [63:0] span;
    begin
      span = 64'(xb) - 64'(xa);
      if (span <= 64'sh0)
        return ya;
      return value_t'(64'(ya) + (64'(x) - 64'(xa)) * (64'(yb) - 64'(ya)) / span);
    end
  endfunction

  function automatic value_t round_val(value_t v, hand_t h);
    begin
      case (h)
        HAND_FLOOR: return v & ~FRAC_MASK;
        HAND_CEIL: return (v + FRAC_MASK) & ~FRAC_MASK;
        HAND_NEAR: return (v + HALF_VAL) & ~FRAC_MASK;
        default: return v;
      endcase
    end
  endfunction

  function automatic value_t clamp_x(value_t v);
    begin
      if (v < 0)
        return '0;
      if (v > IN_LIMIT)
        return IN_LIMIT;
      return v;
    end
  endfunction

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  cfg_t cfg_r [NUM_CURVES];
  cfg_t cfg_nxt [NUM_CURVES];
  value_t x_r [NUM_CURVES][NUM_POINTS];
  value_t x_nxt [NUM_CURVES][NUM_POINTS];
  value_t y_r [NUM_CURVES][NUM_POINTS];
  value_t y_nxt [NUM_CURVES][NUM_POINTS];
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] status_r, status_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] blk;
  logic [1:0] cb;
  logic [7:0] off;
  logic [7:0] xo;
  logic [7:0] yo;
  logic is_x, is_y, is_curve;
  logic [7:0] w1c;

  assign blk = REG_REQ.addr[10:8];
  assign cb = blk[1:0];
  assign off = REG_REQ.addr[7:0];
  assign xo = (off - OFS_X) >> 2;
  assign yo = (off - OFS_Y) >> 2;
  assign is_curve = blk < 3'(NUM_CURVES);
  assign is_x = off >= OFS_X && off < OFS_Y;
  assign is_y = off >= OFS_Y && yo < 8'(NUM_POINTS) && off[1:0] == 2'b00;

  always_comb
  begin
    cfg_nxt = cfg_r;
    x_nxt = x_r;
    y_nxt = y_r;
    mask_nxt = mask_r;
    w1c = '0;
    if (REG_REQ.wr && blk == GLOBAL_BLK)
    begin
      if (off == OFS_STATUS)
        w1c = REG_REQ.wdata[7:0];
      if (off == OFS_MASK)
        mask_nxt = REG_REQ.wdata[7:0];
    end
    else if (REG_REQ.wr && is_curve)
    begin
      case (off)
        OFS_CTRL:
        begin
          cfg_nxt[cb].en = REG_REQ.wdata[CTRL_EN];
          cfg_nxt[cb].filt = REG_REQ.wdata[CTRL_FILT];
          cfg_nxt[cb].oor = REG_REQ.wdata[CTRL_OOR];
          cfg_nxt[cb].hand = hand_t'(REG_REQ.wdata[CTRL_HAND_LSB +: 2]);
          cfg_nxt[cb].sel = REG_REQ.wdata[CTRL_SEL_LSB +: 6];
        end
        OFS_UPD: cfg_nxt[cb].upd = REG_REQ.wdata[15:0];
        OFS_TAU: cfg_nxt[cb].tau = REG_REQ.wdata[19:0];
        OFS_MIN: cfg_nxt[cb].vmin = REG_REQ.wdata;
        OFS_MAX: cfg_nxt[cb].vmax = REG_REQ.wdata;
        OFS_USED: cfg_nxt[cb].used = REG_REQ.wdata[19:0] | USED_FIXED;
        default:
        begin
          if (is_x && off[1:0] == 2'b00)
            x_nxt[cb][xo[4:0]] = clamp_x(REG_REQ.wdata);
          if (is_y)
            y_nxt[cb][yo[4:0]] = REG_REQ.wdata;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Update timing
  // ------------------------------------------------------------
  logic [31:0] step_cnt_r, step_cnt_nxt;
  logic tick;
  logic [15:0] upd_cnt_r [NUM_CURVES];
  logic [15:0] upd_cnt_nxt [NUM_CURVES];
  logic [NUM_CURVES-1:0] pend_r, pend_nxt;
  logic [NUM_CURVES-1:0] done_vec;

  always_comb
  begin
    tick = step_cnt_r == 32'(STEP_CYCLES - 1);
    step_cnt_nxt = tick ? '0 : step_cnt_r + 32'h00000001;
    for (int c = 0; c < NUM_CURVES; c++)
    begin
      upd_cnt_nxt[c] = upd_cnt_r[c];
      pend_nxt[c] = pend_r[c] & ~done_vec[c];
      if (!cfg_r[c].en)
      begin
        upd_cnt_nxt[c] = '0;
        pend_nxt[c] = 1'b0;
      end
      else if (tick)
      begin
        // A zero setting behaves as one step rather than stalling
        if (upd_cnt_r[c] + 16'h0001 >= cfg_r[c].upd)
        begin
          upd_cnt_nxt[c] = '0;
          pend_nxt[c] = 1'b1;
        end
        else
          upd_cnt_nxt[c] = upd_cnt_r[c] + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Curve evaluation
  // ------------------------------------------------------------
  // One shared datapath serves the curves in turn; each pass takes 20 cycles
  state_t state_r, state_nxt;
  logic [1:0] cur_r, cur_nxt;
  logic [1:0] pick;
  logic [4:0] pt_r, pt_nxt;
  logic [4:0] seg_a_r, seg_a_nxt;
  logic [4:0] seg_b_r, seg_b_nxt;
  value_t in_r [NUM_CURVES];
  value_t in_nxt [NUM_CURVES];
  value_t out_r [NUM_CURVES];
  value_t out_nxt [NUM_CURVES];
  logic src_ok;
  value_t raw;
  value_t picked_in;
  value_t cur_in;
  value_t cur_out;

  assign cur_in = in_r[cur_r];
  assign cur_out = out_r[cur_r];
  assign picked_in = in_r[pick];

  always_comb
  begin
    pick = '0;
    for (int c = NUM_CURVES - 1; c >= 0; c--)
      if (pend_r[c])
        pick = 2'(c);
    src_ok = cfg_r[pick].sel < 6'(NUM_SRC) && SRC_VALID[cfg_r[pick].sel];
    raw = src_ok ? SRC_VALUE[cfg_r[pick].sel] : '0;
    state_nxt = state_r;
    cur_nxt = cur_r;
    pt_nxt = pt_r;
    seg_a_nxt = seg_a_r;
    seg_b_nxt = seg_b_r;
    in_nxt = in_r;
    out_nxt = out_r;
    done_vec = '0;
    case (state_r)
      ST_IDLE:
      begin
        if (|pend_r)
        begin
          cur_nxt = pick;
          // A lost source leaves the held value untouched
          if (src_ok)
            in_nxt[pick] = cfg_r[pick].filt ? filt_step(raw, picked_in, cfg_r[pick].upd,
                                                        cfg_r[pick].tau) : raw;
          seg_a_nxt = '0;
          seg_b_nxt = 5'h01;
          pt_nxt = FIRST_EXTRA_PT;
          state_nxt = ST_SCAN;
        end
      end
      ST_SCAN:
      begin
        // Used points must be entered in ascending input order
        if (cfg_r[cur_r].used[pt_r] && cur_in > x_r[cur_r][seg_b_r])
        begin
          seg_a_nxt = seg_b_r;
          seg_b_nxt = pt_r;
        end
        if (pt_r == LAST_PT)
          state_nxt = ST_CALC;
        else
          pt_nxt = pt_r + 5'h01;
      end
      ST_CALC:
      begin
        out_nxt[cur_r] = round_val(interp(cur_in, x_r[cur_r][seg_a_r], x_r[cur_r][seg_b_r],
                                          y_r[cur_r][seg_a_r], y_r[cur_r][seg_b_r]),
                                   cfg_r[cur_r].hand);
        done_vec[cur_r] = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Range flags, status and read data
  // ------------------------------------------------------------
  logic [NUM_CURVES-1:0] oor_r, oor_nxt;
  logic [NUM_CURVES-1:0] oor_en;

  always_comb
  begin
    for (int c = 0; c < NUM_CURVES; c++)
    begin
      oor_en[c] = cfg_r[c].en & cfg_r[c].oor;
      oor_nxt[c] = oor_en[c] & (in_r[c] < cfg_r[c].vmin || in_r[c] > cfg_r[c].vmax);
    end
    // Set beats a same-cycle clear
    status_nxt = (status_r & ~w1c) | {done_vec, oor_nxt & ~oor_r};
    rdata_nxt = '0;
    if (REG_REQ.rd && blk == GLOBAL_BLK)
    begin
      if (off == OFS_STATUS)
        rdata_nxt = 32'(status_r);
      if (off == OFS_MASK)
        rdata_nxt = 32'(mask_r);
    end
    else if (REG_REQ.rd && is_curve)
    begin
      case (off)
        OFS_CTRL:
        begin
          rdata_nxt[CTRL_EN] = cfg_r[cb].en;
          rdata_nxt[CTRL_FILT] = cfg_r[cb].filt;
          rdata_nxt[CTRL_OOR] = cfg_r[cb].oor;
          rdata_nxt[CTRL_HAND_LSB +: 2] = cfg_r[cb].hand;
          rdata_nxt[CTRL_SEL_LSB +: 6] = cfg_r[cb].sel;
        end
        OFS_UPD: rdata_nxt = 32'(cfg_r[cb].upd);
        OFS_TAU: rdata_nxt = 32'(cfg_r[cb].tau);
        OFS_MIN: rdata_nxt = cfg_r[cb].vmin;
        OFS_MAX: rdata_nxt = cfg_r[cb].vmax;
        OFS_USED: rdata_nxt = 32'(cfg_r[cb].used);
        OFS_IN: rdata_nxt = in_r[cb];
        OFS_OUT: rdata_nxt = out_r[cb];
        default:
        begin
          if (is_x && off[1:0] == 2'b00)
            rdata_nxt = x_r[cb][xo[4:0]];
          if (is_y)
            rdata_nxt = y_r[cb][yo[4:0]];
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int c = 0; c < NUM_CURVES; c++)
      begin
        cfg_r[c] <= CFG_RST;
        upd_cnt_r[c] <= '0;
        in_r[c] <= '0;
        out_r[c] <= '0;
        for (int p = 0; p < NUM_POINTS; p++)
        begin
          x_r[c][p] <= (p == 1) ? ONE_VAL : '0;
          y_r[c][p] <= '0;
        end
      end
      mask_r <= '0;
      status_r <= '0;
      rdata_r <= '0;
      step_cnt_r <= '0;
      pend_r <= '0;
      state_r <= ST_IDLE;
      cur_r <= '0;
      pt_r <= '0;
      seg_a_r <= '0;
      seg_b_r <= '0;
      oor_r <= '0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      upd_cnt_r <= upd_cnt_nxt;
      in_r <= in_nxt;
      out_r <= out_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
      step_cnt_r <= step_cnt_nxt;
      pend_r <= pend_nxt;
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      pt_r <= pt_nxt;
      seg_a_r <= seg_a_nxt;
      seg_b_r <= seg_b_nxt;
      oor_r <= oor_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign CURVE_OUT_OF_RANGE = oor_r;
  assign IRQ = |(status_r & mask_r);
  always_comb
    for (int c = 0; c < NUM_CURVES; c++)
      CURVE_VALUE[c] = out_r[c];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb_clk @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_pick;
    state_r == ST_IDLE && |pend_r;
  endsequence

  hold_lost_a:
    assert property (s_pick ##0 !src_ok |=> cur_in == $past(picked_in)) else $error("lost input not held");
  raw_pass_a:
    assert property (s_pick ##0 src_ok && !cfg_r[pick].filt |=> cur_in == $past(raw))
      else $error("unfiltered input not taken");
  filter_bound_a:
    assert property (s_pick ##0 src_ok && cfg_r[pick].filt && raw > picked_in
                     |=> cur_in <= $past(raw) && cur_in >= $past(picked_in)) else $error("filter overshoot");
  oor_gate_a:
    assert property ((CURVE_OUT_OF_RANGE & ~$past(oor_en)) == '0) else $error("range flag while disabled");
  oor_low_a:
    assert property (oor_en[0] && in_r[0] < cfg_r[0].vmin |=> CURVE_OUT_OF_RANGE[0] || !$past(oor_en[0]))
      else $error("low input not flagged");
  scan_len_a:
    assert property (s_pick |-> ##19 state_r == ST_CALC) else $error("scan length wrong");
  seg_order_a:
    assert property (state_r == ST_CALC |-> seg_b_r > seg_a_r && cfg_r[cur_r].used[seg_b_r])
      else $error("bad segment");
  two_point_a:
    assert property (state_r == ST_CALC && cfg_r[cur_r].used[19:2] == '0 |-> seg_a_r == '0 && seg_b_r == 5'h01)
      else $error("two-point segment wrong");
  floor_out_a:
    assert property (state_r == ST_CALC && cfg_r[cur_r].hand == HAND_FLOOR |=> cur_out[FRAC-1:0] == '0)
      else $error("floor left fraction");
  pend_tick_a:
    assert property ($rose(pend_r[0]) |-> $past(tick)) else $error("update off step");
  done_single_a:
    assert property ($onehot0(done_vec)) else $error("two curves done at once");

endmodule

/* File: meas_source.sv */
// Behavioural model of the measurement channels that feed the curves.
// Assumes the bench calls set_src right after a rising clock edge.
`timescale 1ns/100ps
module meas_source
  import curve_pkg::*;
(
  // Raw measurements
  output value_t [NUM_SRC-1:0] SRC_VALUE,
  output logic [NUM_SRC-1:0] SRC_VALID
);
  value_t last_r [NUM_SRC];

  initial
  begin
    SRC_VALUE = '0;
    SRC_VALID = '1;
    for (int i = 0; i < NUM_SRC; i++)
      last_r[i] = '0;
  end

  // A lost channel shows garbage, so a design that keeps sampling it is caught
  task automatic set_src(input int i, input value_t v, input logic ok);
    if (ok)
      last_r[i] = v;
    SRC_VALUE[i] <= ok ? v : ~last_r[i];
    SRC_VALID[i] <= ok;
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the analog scaling curve block.
// Assumes the partner model drives the sources; a 5 ms step is shortened to STEP clocks.
`timescale 1ns/100ps
module testbench
  import curve_pkg::*;
;
  localparam int STEP = 40;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  reg_req_t req = '0;
  logic [31:0] rdata;
  value_t [NUM_SRC-1:0] src_value;
  logic [NUM_SRC-1:0] src_valid;
  value_t [NUM_CURVES-1:0] curve_value;
  logic [NUM_CURVES-1:0] oor;
  logic irq;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t_done;
  logic [31:0] in_v, out_v, rd_v;
  logic [31:0] seed = 32'd43827;
  longint x, prev;

  analog_scaling_curve #(.STEP_CYCLES(STEP)) DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_REQ(req),
    .REG_RDATA(rdata), .SRC_VALUE(src_value), .SRC_VALID(src_valid), .CURVE_VALUE(curve_value),
    .CURVE_OUT_OF_RANGE(oor), .IRQ(irq));
  meas_source src_model (.SRC_VALUE(src_value), .SRC_VALID(src_valid));

  always #2.5 SYS_CLK = ~SYS_CLK;

  // ------------------------------------------------------------
  // Hang guard
  // ------------------------------------------------------------
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Curve used throughout: (0,0) (100,200) and optional (200,0), values in Q8
  function automatic longint model(input longint v, input int hand, input bit seg);
    longint r;
    r = (seg && v > 100 * 256) ? 400 * 256 - 2 * v : 2 * v;
    case (hand)
      1: r = (r >>> 8) <<< 8;
      2: r = ((r + 255) >>> 8) <<< 8;
      3: r = ((r + 128) >>> 8) <<< 8;
      default: ;
    endcase
    return r;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input int a, input logic [31:0] d);
    @(posedge SYS_CLK);
    req <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_W'(a), wdata: d};
    @(posedge SYS_CLK);
    req <= '0;
  endtask

  task automatic rd(input int a, output logic [31:0] d);
    @(posedge SYS_CLK);
    req <= '{wr: 1'b0, rd: 1'b1, addr: ADDR_W'(a), wdata: 32'h0};
    @(posedge SYS_CLK);
    req <= '0;
    // Read data stand for the one cycle after the strobe; take them at its closing edge
    @(posedge SYS_CLK);
    d = rdata;
  endtask

  // Waits for the next finished update of curve c through the done interrupt
  task automatic sample(input int c);
    int n;
    n = 0;
    wr('h404, 32'h1 << (ST_DONE_LSB + c));
    wr('h400, 32'hff);
    #1;
    while (irq !== 1'b1 && n < 500)
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    t_done = cyc;
    check("update done", 32'(irq), 32'h1);
    rd(c * 'h100 + 'h18, in_v);
    rd(c * 'h100 + 'h1c, out_v);
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rd('h000, rd_v);
    check("ctrl reset", rd_v, 32'h0);
    rd('h004, rd_v);
    check("update reset", rd_v, 32'd30);
    rd('h008, rd_v);
    check("tau reset", rd_v, 32'd200);
    rd('h014, rd_v);
    check("used reset", rd_v, 32'h3);
    rd('h024, rd_v);
    check("point two input reset", rd_v, 32'h100);
    rd('h0f0, rd_v);
    check("unmapped read", rd_v, 32'h0);
    check("flag reset", 32'(oor), 32'h0);
    wr('h024, 100 * 256);
    wr('h074, 200 * 256);
    wr('h028, 200 * 256);
    wr('h078, 0);
    wr('h004, 3);
    wr('h000, 32'h501);
    src_model.set_src(5, 50 * 256, 1'b1);
    sample(0);
    sample(0);
    prev = t_done;
    sample(0);
    check("update period", 32'(t_done - prev), 32'(3 * STEP));
    wr('h004, 1);
    for (int h = 0; h < 4; h++)
    begin
      x = rnd() % (100 * 256);
      src_model.set_src(5, value_t'(x), 1'b1);
      wr('h000, 32'h501 | (h << CTRL_HAND_LSB));
      sample(0);
      sample(0);
      check("curve input", in_v, 32'(x));
      check("output register", out_v, 32'(model(x, h, 0)));
      check("curve output", curve_value[0], 32'(model(x, h, 0)));
    end
    wr('h000, 32'h501);
    x = 100 * 256 + 1 + rnd() % (100 * 256);
    src_model.set_src(5, value_t'(x), 1'b1);
    wr('h014, 32'h7);
    sample(0);
    sample(0);
    check("three point output", curve_value[0], 32'(model(x, 0, 1)));
    wr('h014, 32'h3);
    sample(0);
    sample(0);
    check("two point output", curve_value[0], 32'(model(x, 0, 0)));
    src_model.set_src(5, value_t'(x / 2), 1'b0);
    sample(0);
    sample(0);
    check("held input", in_v, 32'(x));
    check("held output", curve_value[0], 32'(model(x, 0, 0)));
    wr('h00c, 10 * 256);
    wr('h010, 150 * 256);
    src_model.set_src(5, 5 * 256, 1'b1);
    sample(0);
    sample(0);
    check("range check off", 32'(oor[0]), 32'h0);
    wr('h000, 32'h505);
    rd('h400, rd_v);
    check("range status", 32'(rd_v[ST_OOR_LSB]), 32'h1);
    check("below minimum", 32'(oor[0]), 32'h1);
    wr('h404, 32'h1);
    @(posedge SYS_CLK);
    check("range interrupt", 32'(irq), 32'h1);
    wr('h400, 32'h1);
    @(posedge SYS_CLK);
    check("range interrupt cleared", 32'(irq), 32'h0);
    src_model.set_src(5, 50 * 256, 1'b1);
    sample(0);
    sample(0);
    check("inside limits", 32'(oor[0]), 32'h0);
    src_model.set_src(5, 200 * 256, 1'b1);
    sample(0);
    sample(0);
    check("above maximum", 32'(oor[0]), 32'h1);
    wr('h008, 3);
    wr('h000, 32'h503);
    src_model.set_src(5, 20 * 256, 1'b1);
    sample(0);
    repeat (3)
    begin
      prev = value_t'(in_v);
      sample(0);
      check("filtered input", in_v, 32'(prev + (20 * 256 - prev) / 4));
    end
    x = rnd() % (4000 * 256);
    src_model.set_src(NUM_SRC - 1, value_t'(x), 1'b1);
    // Default update cycle is far longer than the done wait allows
    wr('h304, 1);
    wr('h300, 32'h2901);
    sample(3);
    sample(3);
    check("fourth curve input", in_v, 32'(x));
    check("fourth curve output", curve_value[3], 32'h0);
    check("fourth curve flag", 32'(oor[3]), 32'h0);
    check("idle curve output", curve_value[1], 32'h0);
    wrap_up();
  end
endmodule
